// ---- hdl/serial_brg_pkg.sv ----
// constants and carrier types for the serial control and baud rate block
// assumes a 12-bit apb byte address and 32-bit data
package serial_brg_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // ****************************************
   // register indices; byte address is index times four
   // ****************************************
   localparam logic [31:0] IDX_BG0_CTRL = 32'hFFFFF233;
   localparam logic [31:0] IDX_BG0_FRAC = 32'hFFFFF234;
   localparam logic [31:0] IDX_BG1_CTRL = 32'hFFFFF23B;
   localparam logic [31:0] IDX_BG1_FRAC = 32'hFFFFF23C;
   localparam logic [31:0] IDX_SC5_CTRL = 32'hFFFFF293;
   localparam logic [31:0] IDX_IRQ_STAT = 32'h000003F0;
   localparam logic [31:0] IDX_IRQ_MASK = 32'h000003F1;

   // ****************************************
   // field positions
   // ****************************************
   localparam int SC_NINTH = 7;
   localparam int SC_EVEN = 6;
   localparam int SC_PEN = 5;
   localparam int SC_OVR = 4;
   localparam int SC_PAR = 3;
   localparam int SC_FRM = 2;
   localparam int SC_EDGE = 1;
   localparam int SC_SRC = 0;
   localparam int BG_FRAC_EN = 6;
   localparam int BG_CK_LSB = 4;
   localparam int BG_DIV_LSB = 0;
   localparam int BG_K_LSB = 0;
   localparam int ERR_W = 3;

   // ****************************************
   // reset values and divider constants
   // ****************************************
   localparam logic [7:0] SC_RESET = 8'h00;
   localparam logic [7:0] BG_RESET = 8'h00;
   localparam logic [3:0] K_RESET = 4'h0;
   localparam logic [ERR_W-1:0] ERR_RESET = 3'h0;
   localparam logic [3:0] DIV_CODE_16 = 4'h0;
   localparam logic [4:0] DIV_SIXTEEN = 5'h10;
   localparam logic [4:0] FRAC_DEN = 5'h10;

   typedef struct packed {
      logic frac_en;
      logic [1:0] clk_sel;
      logic [3:0] divisor;
      logic [3:0] k;
   } brg_cfg_t;

   typedef struct packed {
      logic overrun;
      logic parity_underrun;
      logic framing;
   } err_t;

endpackage

// ---- hdl/level_sync.sv ----
// two-flop synchroniser for levels arriving from outside mclk
// assumes nothing reads the first stage
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;

endmodule
`default_nettype wire

// ---- hdl/baud_divider.sv ----
// one baud rate generator: tap select, integer or N+(16-K)/16 division
// assumes tap inputs are single-cycle strobes on mclk
`timescale 1ns/1ps
`default_nettype none
module baud_divider
   import serial_brg_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // configuration
   input wire serial_brg_pkg::brg_cfg_t cfg,
   input wire logic restart,
   // prescaler taps 0, 2, 8, 32
   input wire logic [3:0] taps,
   // divided output
   output logic tick
);
   import serial_brg_pkg::*;

   logic tap;
   logic [4:0] n_val;
   logic [4:0] sum;
   logic carry;
   logic [4:0] target;
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic [3:0] acc_q;
   logic [3:0] acc_d;
   logic tick_q;
   logic tick_d;

   // ****************************************
   // divisor decode
   // ****************************************
   always_comb begin
      tap = taps[cfg.clk_sel];
      n_val = (cfg.divisor == DIV_CODE_16) ? DIV_SIXTEEN : {1'b0, cfg.divisor};
      // accumulating 16-K per period stretches 16-K of every 16 periods by one
      sum = {1'b0, acc_q} + (FRAC_DEN - {1'b0, cfg.k});
      carry = cfg.frac_en & sum[4];
      target = n_val + {4'h0, carry};
   end

   always_comb begin
      cnt_d = cnt_q;
      acc_d = acc_q;
      tick_d = 1'b0;
      if (restart) begin
         cnt_d = '0;
         acc_d = '0;
      end else if (tap) begin
         if (cnt_q == target - 5'h01) begin
            cnt_d = '0;
            tick_d = 1'b1;
            if (cfg.frac_en) begin
               acc_d = sum[3:0];
            end
         end else begin
            cnt_d = cnt_q + 5'h01;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         cnt_q <= '0;
         acc_q <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         acc_q <= acc_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;

   // ****************************************
   // checks
   // ****************************************
   logic [4:0] gap_q;
   always_ff @(posedge mclk) begin
      if (srst || restart || tick_d) begin
         gap_q <= '0;
      end else if (tap) begin
         gap_q <= gap_q + 5'h01;
      end
   end

   property p_tick_from_tap;
      @(posedge mclk) disable iff (srst) tick_q |-> $past(tap);
   endproperty
   a_tick_from_tap: assert property (p_tick_from_tap) else $error("tick without tap");

   property p_no_early;
      @(posedge mclk) disable iff (srst)
         (tap && !restart && gap_q < n_val - 5'h01) |=> !tick_q;
   endproperty
   a_no_early: assert property (p_no_early) else $error("tick before N taps");

   property p_int_div;
      @(posedge mclk) disable iff (srst)
         (tap && !restart && !cfg.frac_en && gap_q == n_val - 5'h01) |=> tick_q;
   endproperty
   a_int_div: assert property (p_int_div) else $error("no tick at N taps");

   property p_frac_max;
      @(posedge mclk) disable iff (srst)
         (tap && !restart && cfg.frac_en && gap_q == n_val) |=> tick_q;
   endproperty
   a_frac_max: assert property (p_frac_max) else $error("period beyond N+1");

   property p_restart;
      @(posedge mclk) disable iff (srst) restart |=> !tick_q;
   endproperty
   a_restart: assert property (p_restart) else $error("tick right after restart");

endmodule
`default_nettype wire

// ---- hdl/serial_brg.sv ----
// serial channel control and two baud rate generators behind an apb slave
// assumes taps and error events are mclk strobes; the clock pin is asynchronous
// Function
// - error flags are read only and clear when software reads them
// - external clock: edge select zero shifts on rising, one on falling
// - io mode source bit picks baud generator (0) or clock pin (1)
// - parity enable on at one; type odd at zero, even at one
// - input clock field picks prescaler tap 0, 2, 8 or 32
// - divisor codes 2..15 direct, 0 means sixteen, 1 means one
// - fractional enable divides by N plus (16-K)/16, else by N
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module serial_brg
   import serial_brg_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [serial_brg_pkg::ADDR_W-1:0] paddr,
   input wire logic [serial_brg_pkg::DATA_W-1:0] pwdata,
   output logic [serial_brg_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // channel side
   input wire logic uart_mode,
   input wire logic received_ninth_bit,
   input wire serial_brg_pkg::err_t err_event,
   input wire logic [3:0] prescaler_taps,
   input wire logic serial_clock_pin,
   // timing and configuration out
   output logic [1:0] baud_tick,
   output logic shift_tick,
   output logic parity_enable,
   output logic parity_even,
   output logic irq
);
   import serial_brg_pkg::*;

   // ****************************************
   // address decode
   // ****************************************
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] idx);
      hit = (a[ADDR_W-1:2] == idx[ADDR_W-3:0]) && (a[1:0] == 2'h0);
   endfunction

   logic setup;
   logic access;
   logic wr;
   logic rd;
   logic sel_bg_ctrl [2];
   logic sel_bg_frac [2];
   logic sel_sc;
   logic sel_stat;
   logic sel_mask;
   logic mapped;

   always_comb begin
      setup = psel & ~penable;
      access = psel & penable;
      sel_bg_ctrl[0] = hit(paddr, IDX_BG0_CTRL);
      sel_bg_ctrl[1] = hit(paddr, IDX_BG1_CTRL);
      sel_bg_frac[0] = hit(paddr, IDX_BG0_FRAC);
      sel_bg_frac[1] = hit(paddr, IDX_BG1_FRAC);
      sel_sc = hit(paddr, IDX_SC5_CTRL);
      sel_stat = hit(paddr, IDX_IRQ_STAT);
      sel_mask = hit(paddr, IDX_IRQ_MASK);
      mapped = sel_bg_ctrl[0] | sel_bg_ctrl[1] | sel_bg_frac[0] | sel_bg_frac[1]
             | sel_sc | sel_stat | sel_mask;
      wr = access & pwrite & mapped;
      rd = access & ~pwrite & mapped;
   end

   // single-cycle access phase; read data latched in setup
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // ****************************************
   // baud generator registers
   // ****************************************
   brg_cfg_t cfg_q [2];
   brg_cfg_t cfg_d [2];
   logic restart [2];
   logic [1:0] tick_w;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_brg
         always_comb begin
            cfg_d[g] = cfg_q[g];
            restart[g] = (wr & (sel_bg_ctrl[g] | sel_bg_frac[g])) | srst;
            if (wr && sel_bg_ctrl[g]) begin
               cfg_d[g].frac_en = pwdata[BG_FRAC_EN];
               cfg_d[g].clk_sel = pwdata[BG_CK_LSB +: 2];
               cfg_d[g].divisor = pwdata[BG_DIV_LSB +: 4];
            end
            if (wr && sel_bg_frac[g]) begin
               cfg_d[g].k = pwdata[BG_K_LSB +: 4];
            end
         end

         always_ff @(posedge mclk) begin
            if (srst) begin
               cfg_q[g].frac_en <= BG_RESET[BG_FRAC_EN];
               cfg_q[g].clk_sel <= BG_RESET[BG_CK_LSB +: 2];
               cfg_q[g].divisor <= BG_RESET[BG_DIV_LSB +: 4];
               cfg_q[g].k <= K_RESET;
            end else begin
               cfg_q[g] <= cfg_d[g];
            end
         end

         baud_divider u_div (
            .mclk(mclk),
            .srst(srst),
            .cfg(cfg_q[g]),
            .restart(restart[g]),
            .taps(prescaler_taps),
            .tick(tick_w[g])
         );
      end
   endgenerate

   assign baud_tick = tick_w;

   // ****************************************
   // serial control register
   // ****************************************
   logic even_q;
   logic even_d;
   logic pen_q;
   logic pen_d;
   logic edge_q;
   logic edge_d;
   logic src_q;
   logic src_d;
   err_t flag_q;
   err_t flag_d;
   logic sc_read;
   logic [DATA_W-1:0] rdata_q;

   always_comb begin
      even_d = even_q;
      pen_d = pen_q;
      edge_d = edge_q;
      src_d = src_q;
      sc_read = rd & sel_sc;
      if (wr && sel_sc) begin
         even_d = pwdata[SC_EVEN];
         pen_d = pwdata[SC_PEN];
         edge_d = pwdata[SC_EDGE];
         src_d = pwdata[SC_SRC];
      end
      // only flags this read returned are cleared; events since setup survive
      flag_d = sc_read ? ((flag_q & ~rdata_q[SC_FRM +: ERR_W]) | err_event)
                       : (flag_q | err_event);
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         even_q <= SC_RESET[SC_EVEN];
         pen_q <= SC_RESET[SC_PEN];
         edge_q <= SC_RESET[SC_EDGE];
         src_q <= SC_RESET[SC_SRC];
         flag_q <= ERR_RESET;
      end else begin
         even_q <= even_d;
         pen_q <= pen_d;
         edge_q <= edge_d;
         src_q <= src_d;
         flag_q <= flag_d;
      end
   end

   assign parity_enable = pen_q;
   assign parity_even = even_q;

   // ****************************************
   // shift clock selection
   // ****************************************
   logic pin_s;
   logic pin_prev_q;
   logic pin_rise;
   logic pin_fall;
   logic shift_q;
   logic shift_d;

   level_sync #(.WIDTH(1)) u_pin_sync (
      .mclk(mclk),
      .srst(srst),
      .async_in(serial_clock_pin),
      .sync_out(pin_s)
   );

   always_comb begin
      pin_rise = pin_s & ~pin_prev_q;
      pin_fall = ~pin_s & pin_prev_q;
      // uart always runs from its generator; io mode may take the pin
      if (!uart_mode && src_q) begin
         shift_d = edge_q ? pin_fall : pin_rise;
      end else begin
         shift_d = tick_w[0];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_prev_q <= 1'b0;
         shift_q <= 1'b0;
      end else begin
         pin_prev_q <= pin_s;
         shift_q <= shift_d;
      end
   end

   assign shift_tick = shift_q;

   // ****************************************
   // interrupt status and mask
   // ****************************************
   err_t stat_q;
   err_t stat_d;
   err_t mask_q;
   err_t mask_d;

   always_comb begin
      stat_d = stat_q;
      mask_d = mask_q;
      if (wr && sel_stat) begin
         stat_d = stat_q & ~pwdata[ERR_W-1:0];
      end
      stat_d = stat_d | err_event;
      if (wr && sel_mask) begin
         mask_d = pwdata[ERR_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         stat_q <= ERR_RESET;
         mask_q <= ERR_RESET;
      end else begin
         stat_q <= stat_d;
         mask_q <= mask_d;
      end
   end

   assign irq = |(stat_q & mask_q);

   // ****************************************
   // read data
   // ****************************************
   logic [DATA_W-1:0] rdata_d;

   always_comb begin
      rdata_d = rdata_q;
      if (setup) begin
         rdata_d = '0;
         for (int i = 0; i < 2; i++) begin
            if (sel_bg_ctrl[i]) begin
               rdata_d[BG_FRAC_EN] = cfg_q[i].frac_en;
               rdata_d[BG_CK_LSB +: 2] = cfg_q[i].clk_sel;
               rdata_d[BG_DIV_LSB +: 4] = cfg_q[i].divisor;
            end
            if (sel_bg_frac[i]) begin
               rdata_d[BG_K_LSB +: 4] = cfg_q[i].k;
            end
         end
         if (sel_sc) begin
            rdata_d[SC_NINTH] = received_ninth_bit;
            rdata_d[SC_EVEN] = even_q;
            rdata_d[SC_PEN] = pen_q;
            rdata_d[SC_OVR] = flag_q.overrun;
            rdata_d[SC_PAR] = flag_q.parity_underrun;
            rdata_d[SC_FRM] = flag_q.framing;
            rdata_d[SC_EDGE] = edge_q;
            rdata_d[SC_SRC] = src_q;
         end
         if (sel_stat) begin
            rdata_d[ERR_W-1:0] = stat_q;
         end
         if (sel_mask) begin
            rdata_d[ERR_W-1:0] = mask_q;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign prdata = rdata_q;

   // ****************************************
   // checks
   // ****************************************
   property p_flag_clear;
      @(posedge mclk) disable iff (srst)
         (sc_read && err_event == '0) |=> (flag_q & $past(rdata_q[SC_FRM +: ERR_W])) == '0;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared by read");

   property p_flag_set;
      @(posedge mclk) disable iff (srst) err_event.overrun |=> flag_q.overrun;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("overrun event lost");

   property p_edge_fall;
      @(posedge mclk) disable iff (srst)
         (!uart_mode && src_q && edge_q && pin_fall) |=> shift_tick;
   endproperty
   a_edge_fall: assert property (p_edge_fall) else $error("falling edge not used");

   property p_edge_rise;
      @(posedge mclk) disable iff (srst)
         (!uart_mode && src_q && !edge_q && pin_fall) |=> !shift_tick;
   endproperty
   a_edge_rise: assert property (p_edge_rise) else $error("shift on wrong edge");

   property p_src_brg;
      @(posedge mclk) disable iff (srst)
         (!uart_mode && !src_q) |=> shift_tick == $past(baud_tick[0]);
   endproperty
   a_src_brg: assert property (p_src_brg) else $error("shift not from generator");

   property p_parity_write;
      @(posedge mclk) disable iff (srst)
         (wr && sel_sc) |=> (parity_enable == $past(pwdata[SC_PEN]))
                            && (parity_even == $past(pwdata[SC_EVEN]));
   endproperty
   a_parity_write: assert property (p_parity_write) else $error("parity bits not taken");

   property p_irq;
      @(posedge mclk) disable iff (srst) (err_event.framing && mask_q.framing) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("masked-in event gave no irq");

   c_read_clear: cover property (@(posedge mclk) disable iff (srst) flag_q != '0 ##1 sc_read);
   c_pin_shift: cover property (@(posedge mclk) disable iff (srst) src_q && !uart_mode && shift_tick);
   c_frac: cover property (@(posedge mclk) disable iff (srst) cfg_q[0].frac_en && baud_tick[0]);

endmodule
`default_nettype wire

// ---- tb/sclk_device.sv ----
// pin-side model: an outside device that clocks the serial channel
// assumes mclk comes from the bench; pin moves only after mclk edges
`timescale 1ns/1ps
`default_nettype none
module sclk_device (
   // bench clock
   input wire logic mclk,
   // serial clock toward the block
   output logic serial_clock_pin
);
   // ****************
   // frames of pulses
   // ****************
   initial serial_clock_pin = 1'b1;
   // idles high between frames; random half periods give quick and slow edges
   task automatic burst(input int n);
      int h;
      for (int i = 0; i < 2 * n; i++) begin
         h = 2 + int'($urandom % 4);
         repeat (h) @(posedge mclk);
         serial_clock_pin <= ~serial_clock_pin;
      end
   endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the serial control and baud rate block
// assumes the pin device model sclk_device and the design package
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import serial_brg_pkg::*;
   localparam logic [11:0] G0C = {IDX_BG0_CTRL[9:0], 2'b00};
   localparam logic [11:0] G0F = {IDX_BG0_FRAC[9:0], 2'b00};
   localparam logic [11:0] G1C = {IDX_BG1_CTRL[9:0], 2'b00};
   localparam logic [11:0] G1F = {IDX_BG1_FRAC[9:0], 2'b00};
   localparam logic [11:0] SC_A = {IDX_SC5_CTRL[9:0], 2'b00};
   localparam logic [11:0] ST_A = {IDX_IRQ_STAT[9:0], 2'b00};
   localparam logic [11:0] MK_A = {IDX_IRQ_MASK[9:0], 2'b00};
   logic [11:0] regs[7] = '{G0C, G0F, G1C, G1F, SC_A, ST_A, MK_A};
   logic mclk, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic uart_mode = 1'b1, received_ninth_bit = 1'b0, chk_shift = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata, rd;
   logic [3:0] prescaler_taps = 4'h0;
   logic [1:0] baud_tick;
   logic pready, pslverr, shift_tick, parity_enable, parity_even, irq, serial_clock_pin, err;
   logic edge_exp = 1'b0, src_exp = 1'b0, bt_prev = 1'b0, sh_exp;
   logic [5:0] ph = 6'h3F;
   err_t err_event = '0;
   int mismatches = 0, tests_run = 0, cnt = 0, mon_gen = 0, mon_sel = 0;
   int per_q[$];

   serial_brg dut_u (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .uart_mode(uart_mode), .received_ninth_bit(received_ninth_bit),
      .err_event(err_event), .prescaler_taps(prescaler_taps),
      .serial_clock_pin(serial_clock_pin), .baud_tick(baud_tick), .shift_tick(shift_tick),
      .parity_enable(parity_enable), .parity_even(parity_even), .irq(irq));
   sclk_device partner_u (.mclk(mclk), .serial_clock_pin(serial_clock_pin));

   // *****************
   // checks and drivers
   // *****************
   task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp1(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // starts one edge after entry, so a release never meets the next setup
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         mismatches++;
         give_verdict;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp32(what, exp, rd);
   endtask
   task automatic pulse(input logic [2:0] e);
      @(posedge mclk);
      err_event <= err_t'(e);
      @(posedge mclk);
      err_event <= '0;
      repeat (2) @(posedge mclk);
   endtask
   function automatic int exp_sum(input logic [3:0] c, input logic f, input logic [3:0] kk);
      int n;
      n = (c == 4'h0) ? 16 : int'(c);
      return 16 * n + (f ? 16 - int'(kk) : 0);
   endfunction

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      #4500000;
      mismatches++;
      give_verdict;
   end
   always @(posedge mclk) prescaler_taps <= 4'($urandom);
   // taps seen in a tick's own cycle already belong to the next period
   always @(posedge mclk) begin
      if (baud_tick[mon_gen] === 1'b1) begin
         per_q.push_back(cnt);
         cnt = int'(prescaler_taps[mon_sel]);
      end else begin
         cnt += int'(prescaler_taps[mon_sel]);
      end
      if (chk_shift) begin
         // pin change seen here four edges later: between ph[3] and ph[2]
         sh_exp = edge_exp ? (ph[3] & ~ph[2]) : (ph[2] & ~ph[3]);
         cmp1("shift_tick", (uart_mode || !src_exp) ? bt_prev : sh_exp, shift_tick);
      end
      bt_prev = baud_tick[0];
      ph = {ph[4:0], serial_clock_pin};
   end

   // *************
   // main sequence
   // *************
   initial begin
      logic [3:0] code, k;
      logic [1:0] sel;
      logic gen, fe;
      int n, sum;
      void'($urandom(32'hF1B491E3));
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      cmp1("unmapped write error", 1'b1, err);
      apb(1'b0, 12'h004, 32'h0);
      cmp1("unmapped read error", 1'b1, err);
      foreach (regs[i]) rd_chk("reset value", regs[i], 32'h0);
      received_ninth_bit <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, SC_A, {24'h0, 1'b0, 2'(m), 5'h1C});
         rd_chk("serial control", SC_A, {24'h0, 1'b1, 2'(m), 5'h00});
         cmp1("parity enable", m[0], parity_enable);
         cmp1("parity even", m[1], parity_even);
      end
      apb(1'b1, MK_A, 32'h5);
      pulse(3'b010);
      cmp1("irq masked", 1'b0, irq);
      pulse(3'b101);
      cmp1("irq raised", 1'b1, irq);
      rd_chk("flags set", SC_A, 32'hFC);
      rd_chk("flags cleared", SC_A, 32'hE0);
      rd_chk("status", ST_A, 32'h7);
      apb(1'b1, ST_A, 32'h5);
      rd_chk("status cleared", ST_A, 32'h2);
      cmp1("irq low", 1'b0, irq);
      apb(1'b1, MK_A, 32'h7);
      rd_chk("mask", MK_A, 32'h7);
      cmp1("irq unmasked", 1'b1, irq);
      @(negedge mclk);
      chk_shift = 1'b1;
      for (int i = 0; i < 12; i++) begin
         gen = i[2];
         sel = 2'(i % 4);
         fe = (i == 2 || i == 3 || (i > 5 && $urandom_range(1) == 1));
         code = (i == 0) ? 4'h0 : (i == 1) ? 4'h1 : 4'($urandom);
         if (fe) code = 4'($urandom_range(15, 2));
         k = (i == 2) ? 4'hF : (i == 3) ? 4'h1 : 4'($urandom_range(15, 1));
         apb(1'b1, gen ? G1F : G0F, {28'($urandom), k});
         apb(1'b1, gen ? G1C : G0C, {24'($urandom), 1'b0, fe, sel, code});
         @(negedge mclk);
         mon_gen = int'(gen);
         mon_sel = int'(sel);
         per_q.delete();
         n = 0;
         while (per_q.size() < 17 && n < 3000) begin
            @(negedge mclk);
            n++;
         end
         if (per_q.size() < 17) begin
            mismatches++;
            give_verdict;
         end
         sum = 0;
         for (int j = 1; j < 17; j++) sum += per_q[j];
         cmp32("period sum", 32'(exp_sum(code, fe, k)), 32'(sum));
         rd_chk("gen control", gen ? G1C : G0C, {25'h0, fe, sel, code});
         rd_chk("gen fraction", gen ? G1F : G0F, {28'h0, k});
      end
      apb(1'b1, G0C, 32'h03);
      for (int m = 0; m < 3; m++) begin
         @(negedge mclk);
         chk_shift = 1'b0;
         @(posedge mclk);
         uart_mode <= 1'b0;
         apb(1'b1, SC_A, {30'h0, m[1], 1'(m != 0)});
         edge_exp = m[1];
         src_exp = (m != 0);
         repeat (8) @(posedge mclk);
         @(negedge mclk);
         chk_shift = 1'b1;
         partner_u.burst(6);
         repeat (8) @(posedge mclk);
      end
      give_verdict;
   end
endmodule
`default_nettype wire
